// file: sim/aebm_slave.sv
`timescale 1ns/1ns
// ----
// far-side memory, byte rows on an 8-bit or 16-bit port
// ----
module aebm_slave (
  // bus from the master
  input wire logic clk_in,
  input wire logic [7:0] addr_in,
  input wire logic rw_in,
  input wire logic [2:0] space_in,
  input wire logic astb_n_in,
  input wire logic dstb_n_in,
  input wire logic [15:0] wr_in,
  // answers
  output logic [15:0] rd_out,
  output logic ack_hi_n_out,
  output logic ack_lo_n_out,
  output logic fault_n_out,
  output logic vec_n_out,
  // scenario controls
  input wire logic port8_in,
  input wire logic fault_in,
  input wire logic vec_in
);
  logic [7:0] mem [0:255];
  logic [7:0] ae;
  logic [1:0] cnt = 2'h0;
  logic term = 1'b0;
  logic ack;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  initial rd_out = 16'h0000;
  // termination choice; interrupt cycles are left to the vector line while vec_in is set
  assign ae = port8_in ? addr_in : {addr_in[7:1], 1'b0};
  assign ack = term && !fault_in && !(vec_in && space_in == 3'h7);
  assign ack_hi_n_out = !(ack && !port8_in);
  assign ack_lo_n_out = !(ack && port8_in);
  assign fault_n_out = !(term && fault_in);
  assign vec_n_out = !vec_in; // low whenever the vec_in control is set
  // slow answer; termination stays until the address strobe goes high
  always @(posedge clk_in) begin
    if (astb_n_in) begin
      cnt <= 2'h0;
      term <= 1'b0;
    end else if (cnt == 2'h2) begin
      term <= 1'b1;
    end else if (!dstb_n_in) begin
      cnt <= cnt + 2'h1;
    end
  end
  // lanes toggle when idle so stale data never passes for valid
  always @(posedge clk_in) begin
    rd_out <= ~rd_out;
    if (!dstb_n_in && rw_in) begin
      rd_out <= {mem[ae], port8_in ? ~mem[ae] : mem[ae + 8'h01]};
    end
    if (!dstb_n_in && !rw_in) begin
      mem[ae] <= wr_in[15:8];
      if (!port8_in) begin
        mem[ae + 8'h01] <= wr_in[7:0]; // no byte-write masking here
      end
    end
  end
endmodule

// file: sim/async_external_bus_master_bench.sv
`timescale 1ns/1ns
module async_external_bus_master_bench;
  import aebm_pkg::*;
  // ----
  // signals named as the design ports
  // ----
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid_in = 1'b0, req_write_in = 1'b0, req_int_ack_in = 1'b0;
  logic [1:0] req_size_in = 2'h0;
  logic [2:0] req_space_in = 3'h1;
  logic [23:0] req_addr_in = 24'h00_0000;
  logic [31:0] req_wdata_in = 32'h0000_0000;
  logic req_ready_out, done_out, xfer_count_hi_out, xfer_count_lo_out, read_write_out;
  logic address_strobe_n_out, data_strobe_n_out, data_oe_out, halt_n_in;
  logic size_ack_upper_n_in, size_ack_lower_n_in, bus_error_in_n_in, auto_vector_req_n_in;
  logic [1:0] done_status_out;
  logic [2:0] space_code_out;
  logic [31:0] rdata_out;
  logic [23:0] address_out;
  logic [15:0] data_in, data_out, slv_rd;
  logic port8 = 1'b0, fault = 1'b0, vec = 1'b0;
  int n_errors = 0, n_checks = 0, cycles = 0;
  logic [13:0] log_q [$];
  aebm_master uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_size_in(req_size_in), .req_space_in(req_space_in),
    .req_int_ack_in(req_int_ack_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_ready_out(req_ready_out), .done_out(done_out), .done_status_out(done_status_out),
    .rdata_out(rdata_out), .address_out(address_out), .xfer_count_hi_out(xfer_count_hi_out),
    .xfer_count_lo_out(xfer_count_lo_out), .space_code_out(space_code_out),
    .read_write_out(read_write_out), .address_strobe_n_out(address_strobe_n_out),
    .data_strobe_n_out(data_strobe_n_out), .data_in(data_in), .data_out(data_out),
    .data_oe_out(data_oe_out), .size_ack_upper_n_in(size_ack_upper_n_in),
    .size_ack_lower_n_in(size_ack_lower_n_in), .bus_error_in_n_in(bus_error_in_n_in),
    .halt_n_in(halt_n_in), .auto_vector_req_n_in(auto_vector_req_n_in));
  aebm_slave far (.clk_in(ref_clk_in), .addr_in(address_out[7:0]), .rw_in(read_write_out),
    .space_in(space_code_out), .astb_n_in(address_strobe_n_out),
    .dstb_n_in(data_strobe_n_out), .wr_in(data_in), .rd_out(slv_rd),
    .ack_hi_n_out(size_ack_upper_n_in), .ack_lo_n_out(size_ack_lower_n_in),
    .fault_n_out(bus_error_in_n_in), .vec_n_out(auto_vector_req_n_in),
    .port8_in(port8), .fault_in(fault), .vec_in(vec));
  // halt joins every bus error, which must still win
  assign halt_n_in = bus_error_in_n_in;
  assign data_in = data_oe_out ? data_out : slv_rd;
  always #25 ref_clk_in = ~ref_clk_in;
  // ----
  // monitors, checks and bus requests
  // ----
  // a run needs about a hundred cycles; the ceiling only cuts a hang
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      test_done();
    end
  end
  always @(negedge address_strobe_n_out) begin
    log_q.push_back({read_write_out, space_code_out, xfer_count_hi_out, xfer_count_lo_out,
      address_out[7:0]});
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_cyc(input int i, input logic [13:0] exp);
    chk("bus cycle", {18'h0_0000, exp}, {18'h0_0000, log_q[i]});
  endtask
  task automatic tick;
    @(posedge ref_clk_in);
    #5;
  endtask
  task automatic op(input logic w, input logic [1:0] sz, input logic [2:0] sp, input logic ia,
    input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    log_q.delete();
    while (req_ready_out !== 1'b1 && n++ < 50) tick();
    {req_valid_in, req_write_in, req_size_in, req_space_in} = {1'b1, w, sz, sp};
    {req_int_ack_in, req_addr_in, req_wdata_in} = {ia, 16'h0000, a, wd};
    tick();
    req_valid_in = 1'b0;
    while (done_out !== 1'b1 && n++ < 300) tick();
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_sizing;
    op(1'b0, REQ_WORD, SP_USER_DATA, 1'b0, 8'h10, 32'h0000_0000);
    chk("read data", 32'h0000_4A4B, rdata_out);
    chk_cyc(0, {1'b1, SP_USER_DATA, SZ_WORD, 8'h10});
    port8 = 1'b1;
    op(1'b1, REQ_LONG, SP_SUPV_DATA, 1'b0, 8'h20, 32'h1122_3344);
    chk("cycle count", 32'h0000_0004, 32'(log_q.size()));
    for (int i = 0; i < 4; i++) begin
      chk_cyc(i, {1'b0, SP_SUPV_DATA, 2'(4 - i), 8'h20 + 8'(i)});
    end
    port8 = 1'b0;
    op(1'b0, REQ_LONG, SP_SUPV_PROG, 1'b0, 8'h20, 32'h0000_0000);
    chk("read back", 32'h1122_3344, rdata_out);
    chk_cyc(1, {1'b1, SP_SUPV_PROG, SZ_WORD, 8'h22});
    $display("test sizing done");
  endtask
  task automatic t_ends;
    fault = 1'b1;
    op(1'b0, REQ_WORD, SP_USER_PROG, 1'b0, 8'h30, 32'h0000_0000);
    chk("status", 32'(ST_BUS_ERR), 32'(done_status_out));
    fault = 1'b0;
    vec = 1'b1;
    op(1'b0, REQ_BYTE, SP_CONTROL, 1'b1, 8'h06, 32'h0000_0000);
    chk("status", 32'(ST_AUTOVEC), 32'(done_status_out));
    op(1'b0, REQ_BYTE, SP_USER_DATA, 1'b0, 8'h41, 32'h0000_0000);
    chk("status", 32'(ST_OK), 32'(done_status_out));
    chk("read data", 32'h0000_001B, rdata_out);
    vec = 1'b0;
    $display("test endings done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_in);
    #5;
    rst_in = 1'b0;
    tick();
    tick();
    t_sizing();
    t_ends();
    test_done();
  end
endmodule

// file: verilog/aebm_master.sv
`timescale 1ns/1ns
// Behaviour
// R1: 24 address outputs, 16-bit data bus
// R2: address, size, space, direction valid during strobe
// R3: size lines give bytes still remaining
// R4: direction changes only on read/write switch
// R5: three-bit space code selects address space
// R6: address is most significant byte location
// R7: address strobe half clock after start
// R8: read: both strobes together, capture on fall
// R9: write: data half clock, data strobe later
// R10: writes drive all sixteen data lines
// R11: slave ends cycle with size acknowledge
// R12: acknowledge gives port width; extra cycles
// R13: bus error ends cycle, alone or together
// R14: bus error with halt gives bus error
// R15: autovector ends interrupt-acknowledge cycles only
// R16: every port width uses handshake cycles
// R17: acknowledge encoding: wait, 8-bit, 16-bit, reserved
// R18: 8-bit ports sit on the upper lanes
// R19: strobes drop, acknowledges high before next
module aebm_master (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // operand request from the core
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [1:0] req_size_in,
  input wire logic [2:0] req_space_in,
  input wire logic req_int_ack_in,
  input wire logic [aebm_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [aebm_pkg::OPND_W-1:0] req_wdata_in,
  output logic req_ready_out,
  // operand completion
  output logic done_out,
  output logic [1:0] done_status_out,
  output logic [aebm_pkg::OPND_W-1:0] rdata_out,
  // external bus outputs
  output logic [aebm_pkg::ADDR_W-1:0] address_out, // R1
  output logic xfer_count_hi_out,
  output logic xfer_count_lo_out,
  output logic [2:0] space_code_out,
  output logic read_write_out,
  output logic address_strobe_n_out,
  output logic data_strobe_n_out,
  // data bus as three signals
  input wire logic [aebm_pkg::DATA_W-1:0] data_in,
  output logic [aebm_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out,
  // termination inputs
  input wire logic size_ack_upper_n_in,
  input wire logic size_ack_lower_n_in,
  input wire logic bus_error_in_n_in,
  input wire logic halt_n_in,
  input wire logic auto_vector_req_n_in
);
  import aebm_pkg::*;

  // ----------------------------------------
  // operand state
  // ----------------------------------------
  aebm_state_t state;
  logic [2:0] remaining; // bytes left in operand
  logic [ADDR_W-1:0] cur_addr;
  logic [OPND_W-1:0] wbuf;
  logic [OPND_W-1:0] rbuf;
  logic is_write;
  logic is_iack;
  logic half; // second half-clock of a strobe phase
  logic [1:0] stat;
  logic any_ack;
  logic port8;
  logic [2:0] moved;
  logic [OPND_W-1:0] next_rbuf;
  logic [7:0] rd_byte;

  // two phases per cycle emulate the half-clock offsets of the strobes
  assign any_ack = !size_ack_upper_n_in || !size_ack_lower_n_in;
  assign port8 = size_ack_upper_n_in; // lower alone means 8-bit R17
  // a lone byte on a 16-bit port rides the lane that its address selects
  assign rd_byte = (!port8 && cur_addr[0]) ? data_in[7:0] : data_in[DATA_W-1:8];
  always_comb begin
    moved = 3'h2;
    if (port8 || remaining == 3'h1) begin
      moved = 3'h1; // R12
    end
  end

  // read data lands on the upper lanes for an 8-bit port
  always_comb begin
    next_rbuf = rbuf;
    if (moved == 3'h1) begin
      next_rbuf = {rbuf[OPND_W-9:0], rd_byte}; // R18
    end else begin
      next_rbuf = {rbuf[OPND_W-17:0], data_in}; // R18
    end
  end

  // ----------------------------------------
  // bus sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= AEBM_IDLE;
      remaining <= 3'h0;
      cur_addr <= '0;
      wbuf <= '0;
      rbuf <= '0;
      is_write <= 1'b0;
      is_iack <= 1'b0;
      half <= 1'b0;
      stat <= ST_OK;
      req_ready_out <= 1'b0;
      done_out <= 1'b0;
      done_status_out <= ST_OK;
      rdata_out <= '0;
      address_strobe_n_out <= 1'b1;
      data_strobe_n_out <= 1'b1;
      data_oe_out <= 1'b0;
      data_out <= '0;
      address_out <= '0;
      xfer_count_hi_out <= 1'b0;
      xfer_count_lo_out <= 1'b0;
      space_code_out <= SP_USER_DATA;
      read_write_out <= 1'b1;
    end else begin
      done_out <= 1'b0;
      unique case (state)
        AEBM_IDLE: begin
          req_ready_out <= 1'b1;
          if (req_valid_in && req_ready_out) begin
            req_ready_out <= 1'b0;
            remaining <= {1'b0, req_size_in} + 3'h1;
            cur_addr <= req_addr_in;
            wbuf <= req_wdata_in;
            is_write <= req_write_in;
            is_iack <= req_int_ack_in;
            space_code_out <= req_space_in; // R5
            rbuf <= '0;
            stat <= ST_OK;
            state <= AEBM_START;
          end
        end
        AEBM_START: begin
          // cycle start: address, size, direction; space set at request R2
          address_out <= cur_addr; // R6
          xfer_count_hi_out <= remaining[1]; // four bytes left reads as 00 R3
          xfer_count_lo_out <= remaining[0]; // R3
          read_write_out <= !is_write; // changes only here R4
          half <= 1'b0;
          state <= AEBM_STROBE;
        end
        AEBM_STROBE: begin
          // waits for acknowledges released by previous slave R19
          if (!any_ack) begin
            address_strobe_n_out <= 1'b0; // R7
            if (!is_write) begin
              data_strobe_n_out <= 1'b0; // R8
            end
            state <= AEBM_WAIT;
          end
        end
        AEBM_WAIT: begin
          if (is_write && !half) begin
            // all sixteen lines, upper lanes first R10
            if (remaining == 3'h1 && cur_addr[0]) begin
              // odd lone byte on both lanes, port width is unknown yet
              data_out <= {wbuf[OPND_W-1:OPND_W-8], wbuf[OPND_W-1:OPND_W-8]}; // R9
            end else begin
              data_out <= wbuf[OPND_W-1:OPND_W-DATA_W]; // R9
            end
            data_oe_out <= 1'b1;
            half <= 1'b1;
          end else if (is_write && data_strobe_n_out) begin
            data_strobe_n_out <= 1'b0; // R9
          end else if (!bus_error_in_n_in) begin
            // with or without halt the result is a bus error R13 R14
            stat <= ST_BUS_ERR;
            state <= AEBM_END;
          end else if (is_iack && !auto_vector_req_n_in) begin
            stat <= ST_AUTOVEC; // R15
            state <= AEBM_END;
          end else if (any_ack && !(!size_ack_upper_n_in && !size_ack_lower_n_in)) begin
            // handshake termination for every port width R11 R16
            if (!is_write) begin
              rbuf <= next_rbuf; // R8
            end
            wbuf <= (moved == 3'h1) ? {wbuf[OPND_W-9:0], 8'h00} : {wbuf[OPND_W-17:0], 16'h0000};
            remaining <= remaining - moved; // R12
            cur_addr <= cur_addr + ADDR_W'(moved);
            state <= AEBM_END;
          end
        end
        AEBM_END: begin
          address_strobe_n_out <= 1'b1; // R19
          data_strobe_n_out <= 1'b1; // R19
          data_oe_out <= 1'b0;
          state <= AEBM_RECOVER;
        end
        AEBM_RECOVER: begin
          if (stat == ST_OK && remaining != 3'h0) begin
            state <= AEBM_START; // extra cycle for narrow port R12
          end else begin
            done_out <= 1'b1;
            done_status_out <= stat;
            rdata_out <= rbuf;
            state <= AEBM_IDLE;
          end
        end
        default: state <= AEBM_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_ds_write;
    @(posedge ref_clk_in) disable iff (rst_in)
      ($fell(address_strobe_n_out) && is_write)
        |-> data_strobe_n_out ##1 data_strobe_n_out ##1 !data_strobe_n_out;
  endproperty
  a_ds_write: assert property (p_ds_write) else $error("write data strobe timing"); // R9

  property p_ds_read;
    @(posedge ref_clk_in) disable iff (rst_in)
      ($fell(address_strobe_n_out) && !is_write) |-> !data_strobe_n_out;
  endproperty
  a_ds_read: assert property (p_ds_read) else $error("read strobes not together"); // R8

  property p_addr_stable;
    @(posedge ref_clk_in) disable iff (rst_in)
      (!address_strobe_n_out && !$rose(address_strobe_n_out) && $past(!address_strobe_n_out))
        |-> $stable(address_out) && $stable(space_code_out) && $stable(read_write_out);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved under strobe"); // R2

  property p_oe_write;
    @(posedge ref_clk_in) disable iff (rst_in)
      data_oe_out |-> !read_write_out;
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("data driven in read"); // R10

  property p_as_after_start;
    @(posedge ref_clk_in) disable iff (rst_in)
      $fell(address_strobe_n_out) |-> $past(state) == AEBM_STROBE;
  endproperty
  a_as_after_start: assert property (p_as_after_start) else $error("strobe early"); // R7

  property p_ack_release;
    @(posedge ref_clk_in) disable iff (rst_in)
      $fell(address_strobe_n_out) |-> $past(size_ack_upper_n_in && size_ack_lower_n_in);
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("strobe before ack release"); // R19

  property p_bus_error_in_n;
    @(posedge ref_clk_in) disable iff (rst_in)
      (state == AEBM_WAIT && !bus_error_in_n_in && !(is_write && (!half || data_strobe_n_out)))
        |-> ##3 done_out && done_status_out == ST_BUS_ERR;
  endproperty
  a_bus_error_in_n: assert property (p_bus_error_in_n) else $error("bus error not reported"); // R13

  property p_size;
    @(posedge ref_clk_in) disable iff (rst_in)
      $fell(address_strobe_n_out) |-> {xfer_count_hi_out, xfer_count_lo_out} == remaining[1:0];
  endproperty
  a_size: assert property (p_size) else $error("size lines wrong"); // R3

  property p_strobes_off;
    @(posedge ref_clk_in) disable iff (rst_in)
      (state == AEBM_START) |-> address_strobe_n_out && data_strobe_n_out;
  endproperty
  a_strobes_off: assert property (p_strobes_off) else $error("strobe left on"); // R19

  property p_bus_error_in_n_halt;
    @(posedge ref_clk_in) disable iff (rst_in)
      (state == AEBM_WAIT && !bus_error_in_n_in && !halt_n_in
        && !(is_write && (!half || data_strobe_n_out)))
        |-> ##3 done_out && done_status_out == ST_BUS_ERR;
  endproperty
  a_bus_error_in_n_halt: assert property (p_bus_error_in_n_halt) else $error("bus error lost under halt"); // R14

  property p_auto_vector_req_n_iack;
    @(posedge ref_clk_in) disable iff (rst_in)
      (done_out && done_status_out == ST_AUTOVEC) |-> is_iack;
  endproperty
  a_auto_vector_req_n_iack: assert property (p_auto_vector_req_n_iack) else $error("autovector outside acknowledge"); // R15

  property p_rw_start;
    @(posedge ref_clk_in) disable iff (rst_in)
      $changed(read_write_out) |-> $past(state) == AEBM_START && address_strobe_n_out;
  endproperty
  a_rw_start: assert property (p_rw_start) else $error("direction moved mid cycle"); // R4

  property p_addr_msb;
    @(posedge ref_clk_in) disable iff (rst_in)
      $fell(address_strobe_n_out) |-> address_out == cur_addr;
  endproperty
  a_addr_msb: assert property (p_addr_msb) else $error("address not operand byte"); // R6

  // an 8-bit answer moves exactly one byte of the operand
  property p_port8_byte;
    @(posedge ref_clk_in) disable iff (rst_in)
      (state == AEBM_WAIT && bus_error_in_n_in && size_ack_upper_n_in && !size_ack_lower_n_in
        && !(is_iack && !auto_vector_req_n_in) && !(is_write && (!half || data_strobe_n_out)))
        |=> remaining == $past(remaining) - 3'h1;
  endproperty
  a_port8_byte: assert property (p_port8_byte) else $error("narrow port byte count"); // R12

  property p_idle_quiet;
    @(posedge ref_clk_in) disable iff (rst_in)
      (state == AEBM_IDLE) |-> address_strobe_n_out && data_strobe_n_out && !data_oe_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("bus busy while idle"); // R19
endmodule

// file: verilog/aebm_pkg.sv
package aebm_pkg;
  // transfer size codes {hi, lo}: bytes still to move in the operand
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_THREE = 2'h3;
  localparam logic [1:0] SZ_LONG = 2'h0;
  // request size encoding (bytes minus one)
  localparam logic [1:0] REQ_BYTE = 2'h0;
  localparam logic [1:0] REQ_WORD = 2'h1;
  localparam logic [1:0] REQ_LONG = 2'h3;
  // space codes
  localparam logic [2:0] SP_USER_DATA = 3'h1;
  localparam logic [2:0] SP_USER_PROG = 3'h2;
  localparam logic [2:0] SP_SUPV_DATA = 3'h5;
  localparam logic [2:0] SP_SUPV_PROG = 3'h6;
  localparam logic [2:0] SP_CONTROL = 3'h7;
  // widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int OPND_W = 32;
  // bus phases, gray coded from idle through recover
  typedef enum logic [2:0] {
    AEBM_IDLE = 3'h0,
    AEBM_START = 3'h1,
    AEBM_STROBE = 3'h3,
    AEBM_WAIT = 3'h2,
    AEBM_END = 3'h6,
    AEBM_RECOVER = 3'h7
  } aebm_state_t;
  // completion codes
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_BUS_ERR = 2'h1;
  localparam logic [1:0] ST_AUTOVEC = 2'h2;
endpackage
